//--- verilog/i2c_st_pkg.sv
// Shared constants and types for the two-wire slave transmitter block
package i2c_st_pkg;
  // Status codes reported with the prescaler bits at zero
  localparam logic [7:0] ST_OWN_READ = 8'hA8;
  localparam logic [7:0] ST_ARB_READ = 8'hB0;
  localparam logic [7:0] ST_DATA_ACK = 8'hB8;
  localparam logic [7:0] ST_DATA_NACK = 8'hC0;
  localparam logic [7:0] ST_LAST_ACK = 8'hC8;
  localparam logic [7:0] ST_NO_INFO = 8'hF8;
  localparam logic [7:0] ST_BUS_ERR = 8'h00;
  // Master-side codes
  localparam logic [7:0] ST_M_START = 8'h08;
  localparam logic [7:0] ST_M_RESTART = 8'h10;
  localparam logic [7:0] ST_M_ADDR_ACK = 8'h18;
  localparam logic [7:0] ST_M_ADDR_NACK = 8'h20;
  localparam logic [5:0] STATUS_PAD = 6'h00;
  localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Phases of one generated bus clock period
  localparam logic [1:0] PH_SET = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  // Quarter of a generated bus bit, in link clock cycles
  localparam int LINK_CLK_NS = 64;
  localparam int QUARTER_NS = 2500;
  localparam logic [7:0] QUARTER_CYC =
    8'((QUARTER_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);

  typedef enum logic [3:0] {
    L_IDLE, L_ADDR, L_AACK, L_WAIT, L_TX, L_TACK, L_WEND, L_BERR,
    L_MSTART, L_MHOLD, L_MADDR, L_MACK, L_MSTOP
  } link_state_e;

  typedef struct packed {
    logic [1:0] evt_sync;
    logic evt_p;
    logic flag;
    logic [7:0] code;
    logic [7:0] status;
    logic ack_en;
    logic start;
    logic stop;
    logic [7:0] data;
    logic cmd_tgl;
    logic [7:0] cmd_data;
    logic cmd_ack;
    logic cmd_start;
    logic cmd_stop;
  } sys_s;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_p;
    logic sda_p;
    logic [1:0] cmd_sync;
    logic cmd_p;
    logic [1:0] ack_sync;
    logic [1:0] gce_sync;
    logic [13:0] adr_sync;
    link_state_e st;
    logic [3:0] cnt;
    logic [1:0] ph;
    logic [7:0] q;
    logic [7:0] sh;
    logic [7:0] rx;
    logic last;
    logic got_ack;
    logic arb_lost;
    logic busy;
    logic owner;
    logic pend_start;
    logic evt_tgl;
    logic [7:0] evt_code;
    logic scl_oe;
    logic sda_oe;
    logic low;
  } link_s;
endpackage

//--- verilog/i2c_slave_transmit_status.sv
// Two-wire slave transmitter with status codes, bus error and restart
//
// Overview of operation
// (R1) Own read address acked: status A8, load byte
// (R2) Arbitration lost, read-addressed: ack, status B0
// (R3) Sent byte acked: status B8, load next
// (R4) Byte nacked: status C0, not-addressed mode
// (R5) Last byte acked: status C8, not-addressed mode
// (R6) Start request sends START once bus free
// (R7) Flag clear: status reads F8
// (R8) Misplaced START/STOP: flag set, status 00
// (R9) Error recovery by stop bit; stop self-clears
// (R10) Combined transfer turns with repeated START
// (R11) Prescaler bits sit below the status code
// (R12) After last byte master reads all ones
// (R13) Flag cleared only by writing one
// (R14) Hold SCL low while flag set, except on bus error
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_transmit_status (
  // System clock domain
  input wire logic sys_clk,
  input wire logic rst,
  // Link sampling clock domain
  input wire logic link_clk,
  // Software control writes
  input wire logic ctl_write,
  input wire logic ctl_irq_clear,
  input wire logic ctl_ack_enable,
  input wire logic ctl_start,
  input wire logic ctl_stop,
  input wire logic data_write,
  input wire logic [7:0] data_in,
  // Configuration
  input wire logic [6:0] own_slave_address,
  input wire logic general_call_enable,
  input wire logic [1:0] prescaler,
  // Software visible state
  output logic [7:0] bus_status_reg,
  output logic [7:0] bus_data_reg,
  output logic serial_irq_flag,
  output logic ack_enable,
  output logic start_request,
  output logic stop_request_bit,
  // Open-drain bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  i2c_st_pkg::sys_s s, next_s;
  i2c_st_pkg::link_s l, next_l;

  logic evt_new, flag_clear, issue;
  logic scl_s, sda_s, rise, fall, start_det, stop_det, cmd_new, tick;
  logic link_rst, addr_match;

  // System domain
  assign evt_new = s.evt_sync[1] ^ s.evt_p;
  assign flag_clear = ctl_write & ctl_irq_clear & s.flag;
  assign issue = flag_clear | (ctl_write & ~s.flag & ctl_start);

  always_comb begin
    next_s = s;
    next_s.evt_sync = {s.evt_sync[0], l.evt_tgl};
    next_s.evt_p = s.evt_sync[1];
    if (data_write) begin
      next_s.data = data_in;
    end
    if (ctl_write) begin
      next_s.ack_en = ctl_ack_enable;
      next_s.start = ctl_start;
      next_s.stop = ctl_stop;
    end
    if (issue) begin
      next_s.cmd_tgl = ~s.cmd_tgl;
      next_s.cmd_data = s.data;
      next_s.cmd_ack = ctl_ack_enable;
      next_s.cmd_start = ctl_start;
      next_s.cmd_stop = ctl_stop;
      next_s.stop = 1'b0; // [R9]
    end
    if (flag_clear) begin
      next_s.flag = 1'b0; // [R13]
    end
    if (evt_new) begin
      next_s.flag = 1'b1;
      next_s.code = l.evt_code;
    end
    if (next_s.flag) begin
      next_s.status = next_s.code | {i2c_st_pkg::STATUS_PAD, prescaler}; // [R11]
    end else begin
      next_s.status = i2c_st_pkg::ST_NO_INFO; // [R7]
    end
    if (rst) begin
      next_s = '0;
      next_s.evt_sync = s.evt_sync;
      next_s.status = i2c_st_pkg::ST_NO_INFO;
    end
  end

  always_ff @(posedge sys_clk) begin
    s <= next_s;
  end

  // Link domain
  assign link_rst = l.rst_sync[1];
  assign scl_s = l.scl_sync[1];
  assign sda_s = l.sda_sync[1];
  assign rise = scl_s & ~l.scl_p;
  assign fall = ~scl_s & l.scl_p;
  assign start_det = scl_s & l.scl_p & l.sda_p & ~sda_s;
  assign stop_det = scl_s & l.scl_p & ~l.sda_p & sda_s;
  assign cmd_new = l.cmd_sync[1] ^ l.cmd_p;
  assign tick = (l.q == i2c_st_pkg::BYTE_ZERO);
  assign addr_match = l.ack_sync[1] & l.rx[0] &
    ((l.rx[7:1] == l.adr_sync[13:7]) |
     (l.gce_sync[1] & (l.rx[7:1] == i2c_st_pkg::GENERAL_CALL_ADDRESS)));

  function automatic i2c_st_pkg::link_s post(input i2c_st_pkg::link_s v,
                                             input logic [7:0] code);
    post = v;
    post.evt_code = code;
    post.evt_tgl = ~v.evt_tgl;
  endfunction

  always_comb begin
    next_l = l;
    next_l.rst_sync = {l.rst_sync[0], rst};
    next_l.scl_sync = {l.scl_sync[0], scl_in};
    next_l.sda_sync = {l.sda_sync[0], sda_in};
    next_l.scl_p = l.scl_sync[1];
    next_l.sda_p = l.sda_sync[1];
    next_l.cmd_sync = {l.cmd_sync[0], s.cmd_tgl};
    next_l.cmd_p = l.cmd_sync[1];
    next_l.ack_sync = {l.ack_sync[0], s.ack_en};
    next_l.gce_sync = {l.gce_sync[0], general_call_enable};
    next_l.adr_sync = {l.adr_sync[6:0], own_slave_address};
    next_l.low = 1'b0;
    if (!tick) begin
      next_l.q = l.q - 8'h01;
    end
    if (start_det) begin
      next_l.busy = 1'b1;
    end
    if (stop_det) begin
      next_l.busy = 1'b0;
      next_l.owner = 1'b0;
    end
    case (l.st)
      i2c_st_pkg::L_IDLE: begin
        // Not addressed: lines released, master reads ones [R12]
        if (cmd_new && s.cmd_start) begin
          next_l.pend_start = 1'b1;
        end
        if (start_det) begin
          next_l.st = i2c_st_pkg::L_ADDR;
          next_l.cnt = '0;
          next_l.arb_lost = 1'b0;
        end else if (l.pend_start && !l.busy) begin
          next_l.pend_start = 1'b0; // [R6]
          next_l.st = i2c_st_pkg::L_MSTART;
          next_l.ph = i2c_st_pkg::PH_SET;
          next_l.q = i2c_st_pkg::QUARTER_CYC;
        end
      end
      i2c_st_pkg::L_ADDR: begin
        if (rise) begin
          next_l.rx = {l.rx[6:0], sda_s};
          next_l.cnt = l.cnt + i2c_st_pkg::CNT_ONE;
        end
        if (fall && l.cnt == i2c_st_pkg::BITS_PER_BYTE) begin
          if (addr_match) begin
            next_l.sda_oe = 1'b1; // [R2]
            next_l.st = i2c_st_pkg::L_AACK;
          end else begin
            next_l.st = i2c_st_pkg::L_IDLE; // [R4] [R5]
          end
        end
      end
      i2c_st_pkg::L_AACK: begin
        if (fall) begin
          next_l.sda_oe = 1'b0;
          next_l.scl_oe = 1'b1; // [R14]
          next_l.st = i2c_st_pkg::L_WAIT;
          next_l = post(next_l, l.arb_lost ? i2c_st_pkg::ST_ARB_READ
                                           : i2c_st_pkg::ST_OWN_READ); // [R1] [R2]
        end
      end
      i2c_st_pkg::L_WAIT: begin
        if (cmd_new) begin
          next_l.sh = s.cmd_data;
          next_l.last = ~s.cmd_ack; // [R1] [R3]
          next_l.cnt = '0;
          next_l.sda_oe = ~s.cmd_data[7];
          next_l.ph = i2c_st_pkg::PH_SET;
          next_l.q = i2c_st_pkg::QUARTER_CYC;
          next_l.st = i2c_st_pkg::L_TX;
        end
      end
      i2c_st_pkg::L_TX: begin
        // Data set up for a quarter bit before SCL is let go
        if (l.ph == i2c_st_pkg::PH_SET) begin
          if (tick) begin
            next_l.scl_oe = 1'b0;
            next_l.ph = i2c_st_pkg::PH_RISE;
          end
        end else if (fall) begin
          next_l.cnt = l.cnt + i2c_st_pkg::CNT_ONE;
          if (l.cnt == i2c_st_pkg::LAST_BIT) begin
            next_l.sda_oe = 1'b0;
            next_l.st = i2c_st_pkg::L_TACK;
          end else begin
            next_l.sh = {l.sh[6:0], 1'b0};
            next_l.sda_oe = ~l.sh[6];
          end
        end
      end
      i2c_st_pkg::L_TACK: begin
        if (rise) begin
          next_l.got_ack = ~sda_s;
        end
        if (fall) begin
          next_l.scl_oe = 1'b1; // [R14]
          if (!l.got_ack) begin
            next_l.st = i2c_st_pkg::L_WEND;
            next_l = post(next_l, i2c_st_pkg::ST_DATA_NACK); // [R4]
          end else if (l.last) begin
            next_l.st = i2c_st_pkg::L_WEND;
            next_l = post(next_l, i2c_st_pkg::ST_LAST_ACK); // [R5]
          end else begin
            next_l.st = i2c_st_pkg::L_WAIT;
            next_l = post(next_l, i2c_st_pkg::ST_DATA_ACK); // [R3]
          end
        end
      end
      i2c_st_pkg::L_WEND: begin
        if (cmd_new) begin
          next_l.scl_oe = 1'b0;
          next_l.pend_start = s.cmd_start; // [R6]
          next_l.st = i2c_st_pkg::L_IDLE; // [R4] [R5]
        end
      end
      i2c_st_pkg::L_BERR: begin
        if (cmd_new && s.cmd_stop) begin
          next_l.st = i2c_st_pkg::L_IDLE; // [R9]
        end
      end
      i2c_st_pkg::L_MSTART: begin
        // Release SDA, release SCL, pull SDA, pull SCL
        if (tick) begin
          next_l.q = i2c_st_pkg::QUARTER_CYC;
          next_l.ph = l.ph + 2'h1;
          case (l.ph)
            i2c_st_pkg::PH_SET: next_l.sda_oe = 1'b0;
            i2c_st_pkg::PH_RISE: next_l.scl_oe = 1'b0;
            i2c_st_pkg::PH_HIGH: next_l.sda_oe = 1'b1;
            default: begin
              next_l.scl_oe = 1'b1;
              next_l.owner = 1'b1;
              next_l.st = i2c_st_pkg::L_MHOLD;
              next_l = post(next_l, l.owner ? i2c_st_pkg::ST_M_RESTART
                                            : i2c_st_pkg::ST_M_START);
            end
          endcase
        end
      end
      i2c_st_pkg::L_MHOLD: begin
        if (cmd_new) begin
          next_l.ph = i2c_st_pkg::PH_SET;
          next_l.q = i2c_st_pkg::QUARTER_CYC;
          if (s.cmd_stop) begin
            next_l.st = i2c_st_pkg::L_MSTOP;
          end else if (s.cmd_start) begin
            // No STOP in between, so the bus stays ours
            next_l.st = i2c_st_pkg::L_MSTART; // [R10]
          end else begin
            next_l.sh = s.cmd_data;
            next_l.cnt = '0;
            next_l.arb_lost = 1'b0;
            next_l.st = i2c_st_pkg::L_MADDR;
          end
        end
      end
      i2c_st_pkg::L_MADDR: begin
        if (tick) begin
          next_l.q = i2c_st_pkg::QUARTER_CYC;
          next_l.ph = l.ph + 2'h1;
          case (l.ph)
            i2c_st_pkg::PH_SET: next_l.sda_oe = ~l.sh[7];
            i2c_st_pkg::PH_RISE: next_l.scl_oe = 1'b0;
            i2c_st_pkg::PH_HIGH: begin
              next_l.rx = {l.rx[6:0], sda_s};
              next_l.cnt = l.cnt + i2c_st_pkg::CNT_ONE;
              if (l.sh[7] && !sda_s) begin
                // Lost: keep listening for our own address [R2]
                next_l.arb_lost = 1'b1;
                next_l.owner = 1'b0;
                next_l.st = i2c_st_pkg::L_ADDR;
              end
            end
            default: begin
              next_l.scl_oe = 1'b1;
              next_l.sh = {l.sh[6:0], 1'b0};
              if (l.cnt == i2c_st_pkg::BITS_PER_BYTE) begin
                next_l.st = i2c_st_pkg::L_MACK;
              end
            end
          endcase
        end
      end
      i2c_st_pkg::L_MACK: begin
        if (tick) begin
          next_l.q = i2c_st_pkg::QUARTER_CYC;
          next_l.ph = l.ph + 2'h1;
          case (l.ph)
            i2c_st_pkg::PH_SET: next_l.sda_oe = 1'b0;
            i2c_st_pkg::PH_RISE: next_l.scl_oe = 1'b0;
            i2c_st_pkg::PH_HIGH: next_l.got_ack = ~sda_s;
            default: begin
              next_l.scl_oe = 1'b1;
              next_l.st = i2c_st_pkg::L_MHOLD;
              next_l = post(next_l, l.got_ack ? i2c_st_pkg::ST_M_ADDR_ACK
                                              : i2c_st_pkg::ST_M_ADDR_NACK);
            end
          endcase
        end
      end
      i2c_st_pkg::L_MSTOP: begin
        if (tick) begin
          next_l.q = i2c_st_pkg::QUARTER_CYC;
          next_l.ph = l.ph + 2'h1;
          case (l.ph)
            i2c_st_pkg::PH_SET: next_l.sda_oe = 1'b1;
            i2c_st_pkg::PH_RISE: next_l.scl_oe = 1'b0;
            default: begin
              next_l.sda_oe = 1'b0;
              next_l.owner = 1'b0;
              next_l.st = i2c_st_pkg::L_IDLE;
            end
          endcase
        end
      end
      default: next_l.st = i2c_st_pkg::L_IDLE;
    endcase
    // START or STOP inside a byte or acknowledge of a slave transfer
    if ((start_det || stop_det) &&
        ((l.st == i2c_st_pkg::L_ADDR && l.cnt != '0) ||
         l.st == i2c_st_pkg::L_AACK || l.st == i2c_st_pkg::L_TX ||
         l.st == i2c_st_pkg::L_TACK)) begin
      next_l.st = i2c_st_pkg::L_BERR; // [R8]
      next_l.scl_oe = 1'b0;
      next_l.sda_oe = 1'b0; // [R9]
      next_l = post(next_l, i2c_st_pkg::ST_BUS_ERR); // [R8]
    end
    if (link_rst) begin
      next_l.st = i2c_st_pkg::L_IDLE;
      next_l.cnt = '0;
      next_l.ph = i2c_st_pkg::PH_SET;
      next_l.q = '0;
      next_l.sh = '0;
      next_l.rx = '0;
      next_l.last = 1'b0;
      next_l.got_ack = 1'b0;
      next_l.arb_lost = 1'b0;
      next_l.busy = 1'b0;
      next_l.owner = 1'b0;
      next_l.pend_start = 1'b0;
      next_l.evt_tgl = 1'b0;
      next_l.evt_code = i2c_st_pkg::ST_NO_INFO;
      next_l.scl_oe = 1'b0;
      next_l.sda_oe = 1'b0;
      next_l.cmd_p = l.cmd_sync[1];
    end
  end

  always_ff @(posedge link_clk) begin
    l <= next_l;
  end

  assign bus_status_reg = s.status;
  assign bus_data_reg = s.data;
  assign serial_irq_flag = s.flag;
  assign ack_enable = s.ack_en;
  assign start_request = s.start;
  assign stop_request_bit = s.stop;
  assign scl_out = l.low;
  assign scl_oe = l.scl_oe;
  assign sda_out = l.low;
  assign sda_oe = l.sda_oe;
endmodule
`default_nettype wire

//--- dv/i2c_bus_master_model.sv
// Behavioural bus master receiver for the two-wire link
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_master_model #(
  parameter int Q = 6
) (
  // Link timing and resolved bus levels
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda,
  // Open-drain pulls, high pulls the line low
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic q();
    repeat (Q) @(negedge link_clk);
  endtask

  // Release SCL and wait out stretching by the slave
  task automatic rise();
    scl_low = 1'b0;
    for (int n = 0; n < 20000 && !scl; n++) @(negedge link_clk);
    q();
  endtask

  task automatic start();
    sda_low = 1'b0;
    q();
    rise();
    sda_low = 1'b1;
    q();
    scl_low = 1'b1;
    q();
  endtask

  task automatic stop();
    sda_low = 1'b1;
    q();
    rise();
    sda_low = 1'b0;
    q();
  endtask

  task automatic clk_bit(input logic b, output logic r);
    sda_low = !b;
    q();
    rise();
    r = sda;
    scl_low = 1'b1;
    q();
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask

  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(!ack, r);
  endtask
endmodule
`default_nettype wire

//--- dv/i2c_st_checker.sv
// Concurrent checks on the slave transmitter's top ports
`timescale 1ns/100ps
`default_nettype none
module i2c_st_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Software side
  input wire logic ctl_write,
  input wire logic ctl_irq_clear,
  input wire logic ctl_ack_enable,
  input wire logic ctl_stop,
  input wire logic [1:0] prescaler,
  input wire logic [7:0] bus_status_reg,
  input wire logic serial_irq_flag,
  input wire logic ack_enable,
  input wire logic stop_request_bit,
  // Bus pull enables
  input wire logic scl_oe,
  input wire logic sda_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic clr;
  logic err;
  logic [7:0] code;
  assign clr = ctl_write && ctl_irq_clear;
  assign err = serial_irq_flag && bus_status_reg == 8'h00;
  assign code = bus_status_reg & 8'hFC;

  no_info_a: assert property (
    !serial_irq_flag |-> bus_status_reg == i2c_st_pkg::ST_NO_INFO)
    else $error("status not F8 while flag clear");
  flag_hold_a: assert property (
    serial_irq_flag && !clr |=> serial_irq_flag)
    else $error("flag dropped without a clear");
  flag_clear_a: assert property (
    serial_irq_flag && clr |=> !serial_irq_flag)
    else $error("flag not cleared by writing one");
  code_set_a: assert property (
    $rose(serial_irq_flag) |-> code inside {8'hA8, 8'hB0, 8'hB8,
      8'hC0, 8'hC8, 8'h00, 8'h08, 8'h10, 8'h18, 8'h20})
    else $error("unknown status code posted");
  prescale_a: assert property (
    serial_irq_flag && $stable(prescaler) |->
      bus_status_reg[1:0] == prescaler)
    else $error("prescaler bits wrong in status");
  hold_scl_a: assert property (
    serial_irq_flag && !err |-> scl_oe)
    else $error("clock not held while flag set");
  err_recover_a: assert property (
    err && clr && ctl_stop |-> ##[1:4]
      (!serial_irq_flag && !stop_request_bit))
    else $error("bus error recovery incomplete");
  err_release_a: assert property (
    err && clr && ctl_stop |-> ##[8:100] (!scl_oe && !sda_oe))
    else $error("lines not released after recovery");
  ack_write_a: assert property (
    ctl_write |=> ack_enable == $past(ctl_ack_enable))
    else $error("acknowledge enable not written");

  cover property ($rose(serial_irq_flag) && code == 8'hA8);
  cover property ($rose(serial_irq_flag) && code == 8'hC8);
  cover property ($rose(serial_irq_flag) && code == 8'h00);
endmodule
`default_nettype wire

//--- dv/tb.sv
// Testbench for the two-wire slave transmitter block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  failures++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb;
  localparam logic [6:0] ADDR = 7'h2D;
  typedef struct packed {
    logic ae;
    logic mack;
    logic [1:0] pre;
    logic [7:0] code;
  } row_s;
  row_s rows [4] = '{'{1'b1, 1'b1, 2'h0, 8'hB8}, '{1'b1, 1'b0, 2'h1, 8'hC0},
    '{1'b0, 1'b1, 2'h2, 8'hC8}, '{1'b0, 1'b0, 2'h3, 8'hC0}};
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic ctl_write = 1'b0;
  logic ctl_irq_clear = 1'b0;
  logic ctl_ack_enable = 1'b0;
  logic ctl_start = 1'b0;
  logic ctl_stop = 1'b0;
  logic data_write = 1'b0;
  logic [7:0] data_in = 8'h00;
  logic [1:0] prescaler = 2'h0;
  logic general_call_enable = 1'b0;
  logic [7:0] bus_status_reg, bus_data_reg, d, g;
  logic serial_irq_flag, ack_enable, start_request, stop_request_bit, a;
  logic scl_out, scl_oe, sda_out, sda_oe, m_scl_low, m_sda_low;
  wire logic scl;
  wire logic sda;
  int failures = 0;
  int n_checks = 0;

  // Pull-ups on both lines
  assign scl = (scl_oe ? scl_out : 1'b1) & !m_scl_low;
  assign sda = (sda_oe ? sda_out : 1'b1) & !m_sda_low;

  always #4 sys_clk = ~sys_clk;
  initial begin
    #13;
    forever #32 link_clk = ~link_clk;
  end

  i2c_slave_transmit_status dut (
    .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
    .ctl_write(ctl_write), .ctl_irq_clear(ctl_irq_clear),
    .ctl_ack_enable(ctl_ack_enable), .ctl_start(ctl_start),
    .ctl_stop(ctl_stop), .data_write(data_write), .data_in(data_in),
    .own_slave_address(ADDR), .general_call_enable(general_call_enable),
    .prescaler(prescaler), .bus_status_reg(bus_status_reg),
    .bus_data_reg(bus_data_reg), .serial_irq_flag(serial_irq_flag),
    .ack_enable(ack_enable), .start_request(start_request),
    .stop_request_bit(stop_request_bit), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe));

  i2c_bus_master_model m (
    .link_clk(link_clk), .scl(scl), .sda(sda),
    .scl_low(m_scl_low), .sda_low(m_sda_low));

  task automatic ctl(input logic c, ae, s, p);
    @(negedge sys_clk);
    ctl_write = 1'b1;
    ctl_irq_clear = c;
    ctl_ack_enable = ae;
    ctl_start = s;
    ctl_stop = p;
    @(negedge sys_clk);
    ctl_write = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic load(input logic [7:0] v);
    @(negedge sys_clk);
    data_write = 1'b1;
    data_in = v;
    @(negedge sys_clk);
    data_write = 1'b0;
  endtask

  task automatic expect_code(input logic [7:0] c);
    for (int n = 0; n < 5000 && serial_irq_flag !== 1'b1; n++)
      @(negedge sys_clk);
    `CHK("status", c | {6'h00, prescaler}, bus_status_reg)
  endtask

  task automatic print_verdict();
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #700000;
    failures++;
    print_verdict();
  end

  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    // Let the link side leave its own synchronised reset first
    repeat (40) @(negedge sys_clk);
    `CHK("reset status", 8'hF8, bus_status_reg)
    `CHK("reset flag", 1'b0, serial_irq_flag)
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    foreach (rows[i]) begin
      @(negedge sys_clk);
      prescaler = rows[i].pre;
      d = 8'h3C ^ (8'h55 << i);
      m.start();
      m.send_byte({ADDR, 1'b1}, a);
      `CHK("addr ack", 1'b1, a)
      expect_code(8'hA8);
      if (i == 0) begin
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        `CHK("flag held", 1'b1, serial_irq_flag)
      end
      load(d);
      ctl(1'b1, rows[i].ae, 1'b0, 1'b0);
      `CHK("no info", 8'hF8, bus_status_reg)
      m.read_byte(rows[i].mack, g);
      `CHK("byte", d, g)
      expect_code(rows[i].code);
      if (rows[i].code == 8'hB8) begin
        load(~d);
        ctl(1'b1, 1'b0, 1'b0, 1'b0);
        m.read_byte(1'b0, g);
        `CHK("next byte", ~d, g)
        expect_code(8'hC0);
      end
      ctl(1'b1, 1'b1, 1'b0, 1'b0);
      if (rows[i].code == 8'hC8) begin
        m.read_byte(1'b0, g);
        `CHK("ones", 8'hFF, g)
      end
      m.stop();
    end
    prescaler = 2'h0;
    ctl(1'b0, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 3; k++) begin
      if (k == 1)
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
      m.start();
      m.send_byte(k == 1 ? {ADDR ^ 7'h01, 1'b1} : {ADDR, k == 0}, a);
      `CHK("ignored", 1'b0, a)
      m.stop();
    end
    general_call_enable = 1'b1;
    m.start();
    m.send_byte(8'h01, a);
    `CHK("general call", 1'b1, a)
    expect_code(8'hA8);
    load(8'h5A);
    ctl(1'b1, 1'b0, 1'b0, 1'b0);
    m.read_byte(1'b0, g);
    `CHK("gc byte", 8'h5A, g)
    expect_code(8'hC0);
    ctl(1'b1, 1'b1, 1'b0, 1'b0);
    m.stop();
    general_call_enable = 1'b0;
    `CHK("idle flag", 1'b0, serial_irq_flag)
    m.start();
    for (int k = 0; k < 3; k++) m.clk_bit(1'b0, a);
    m.stop();
    expect_code(8'h00);
    ctl(1'b1, 1'b1, 1'b0, 1'b1);
    repeat (100) @(negedge sys_clk);
    `CHK("recover", 4'h4, {serial_irq_flag, ack_enable, stop_request_bit,
      scl_oe | sda_oe})
    m.start();
    m.send_byte({ADDR, 1'b1}, a);
    expect_code(8'hA8);
    load(8'h81);
    ctl(1'b1, 1'b0, 1'b0, 1'b0);
    m.read_byte(1'b0, g);
    expect_code(8'hC0);
    ctl(1'b1, 1'b1, 1'b1, 1'b0);
    `CHK("start req", 1'b1, start_request)
    m.stop();
    expect_code(8'h08);
    `CHK("scl held", 1'b1, scl_oe)
    ctl(1'b1, 1'b1, 1'b1, 1'b0);
    expect_code(8'h10);
    `CHK("bus kept", 1'b1, scl_oe)
    ctl(1'b1, 1'b1, 1'b0, 1'b1);
    for (int n = 0; n < 5000 && (scl_oe | sda_oe) !== 1'b0; n++)
      @(negedge sys_clk);
    `CHK("bus free", 3'h6, {scl, sda, serial_irq_flag})
    print_verdict();
  end
endmodule

bind i2c_slave_transmit_status i2c_st_checker chk (
  .sys_clk(sys_clk), .rst(rst), .ctl_write(ctl_write),
  .ctl_irq_clear(ctl_irq_clear), .ctl_ack_enable(ctl_ack_enable),
  .ctl_stop(ctl_stop), .prescaler(prescaler),
  .bus_status_reg(bus_status_reg), .serial_irq_flag(serial_irq_flag),
  .ack_enable(ack_enable), .stop_request_bit(stop_request_bit),
  .scl_oe(scl_oe), .sda_oe(sda_oe));
`default_nettype wire
